//--- tsq_sequencer.sv
// Touch screen and converter reading sequencer with register port.
// Assumes a converter core that answers conv_req.start with conv_done.
//
// Summary of operation
// - Channel 8 converts two thirds of backup cell voltage.
// - Channel 8 reading of backup cell stays available below disconnect threshold.
// - Unused panel terminals serve as general inputs on channels 12 to 15.
// - Detected pen with bias enabled sets pen flag; interrupt unless masked.
// - Pen detection works only while touch readout is disabled.
// - Touch reference is on only while a touch sequence runs, delays and dummy slots included.
// - Coordinate readings return the 10-bit converter value unchanged.
// - Contact reading returns twice the drop across contact resistance.
// - X reading biases x1 and x2, samples y1.
// - Y reading biases y1 and y2, samples x1.
// - Contact reading drives current into y1, grounds x2, converts y2 minus x1.
// - Touch sequence runs slot zero through the last slot field.
// - Slot code selects dummy, X, Y or contact.
// - Dummy pre-biases references and stores zero.
// - Touch sequence preempts a general sequence and overwrites its results.
// - Three 4-bit delays in 40 us steps, reset to zero.
// - Each conversion finishes within 10 us.
// - General sequence completion raises its own maskable done flag.
`timescale 1ns/100ps
module tsq_sequencer
	import tsq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rd_data,
	// Converter core
	output tsq_conv_req_t conv_req,
	input wire logic conv_done,
	input wire logic [9:0] conv_data,
	// Panel
	output tsq_drive_t drive,
	input wire logic pen_detect_in,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [15:0] wait_cnt_reg;
	logic ts_en_reg, pen_en_reg, ts_start_reg, gen_start_reg;
	logic [2:0] ts_last_reg, gen_last_reg;
	logic [3:0] dly_first_reg, dly_between_reg, dly_trail_reg;
	logic [15:0] slots_reg;
	logic [31:0] gen_chan_reg;
	logic [2:0] status_reg, mask_reg;
	logic [9:0] res_reg [8];
	tsq_state_t state_reg;
	logic is_touch_reg;
	logic [2:0] slot_reg, store_slot_reg;
	logic [15:0] cnt_reg;
	logic store_reg, ts_done_reg, gen_done_reg;
	logic [9:0] store_val_reg;
	tsq_conv_req_t conv_req_reg;
	tsq_drive_t drive_reg;
	logic irq_reg;
	logic [31:0] rd_data_reg;
	logic [31:0] read_val;
	logic wr_ctrl, ts_begin, adv, pen_evt, ts_active;
	tsq_action_t cur_act;
	logic [3:0] cur_chan;
	logic [2:0] cur_last;

	function automatic logic [15:0] dly_cycles(input logic [3:0] f);
		dly_cycles = 16'(f * DLY_STEP_CYC);
	endfunction

	function automatic tsq_conv_req_t action_req(input tsq_action_t a);
		tsq_conv_req_t r;
		r = '0;
		r.start = 1'b1;
		case (a)
			ACT_X: r.chan = CH_Y1;
			ACT_Y: r.chan = CH_X1;
			ACT_CONTACT: begin
				r.chan = CH_Y2;
				r.diff = 1'b1;
				r.gain2 = 1'b1;
			end
			default: r.start = 1'b0;
		endcase
		return r;
	endfunction

	function automatic tsq_drive_t action_drive(input tsq_action_t a);
		tsq_drive_t d;
		d = '0;
		d.ref_en = 1'b1;
		case (a)
			ACT_X: d.x_bias = 1'b1;
			ACT_Y: d.y_bias = 1'b1;
			ACT_CONTACT: begin
				d.cur_y1 = 1'b1;
				d.gnd_x2 = 1'b1;
			end
			default: d.ref_en = 1'b1;
		endcase
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Shared decode
	assign wr_ctrl = wr_stb && (addr == OFS_CTRL);
	assign cur_act = tsq_action_t'(slots_reg[2 * slot_reg +: 2]);
	assign cur_chan = gen_chan_reg[4 * slot_reg +: 4];
	assign cur_last = is_touch_reg ? ts_last_reg : gen_last_reg;
	assign ts_active = (state_reg != ST_IDLE) && is_touch_reg;
	assign ts_begin = ts_start_reg && ts_en_reg && !ts_active;
	assign adv = (state_reg == ST_ISSUE && is_touch_reg && cur_act == ACT_DUMMY)
		|| (state_reg == ST_WAIT && (conv_done || cnt_reg == 16'h0000));
	assign pen_evt = pen_detect_in && pen_en_reg && !ts_en_reg;

	////////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ts_en_reg <= 1'b0;
			pen_en_reg <= 1'b0;
			ts_last_reg <= LAST_RST;
			gen_last_reg <= LAST_RST;
			dly_first_reg <= DLY_RST;
			dly_between_reg <= DLY_RST;
			dly_trail_reg <= DLY_RST;
			slots_reg <= SLOTS_RST;
			gen_chan_reg <= GEN_CHAN_RST;
			mask_reg <= MASK_RST;
		end else if (wr_stb) begin
			if (addr == OFS_CTRL) begin
				ts_en_reg <= wr_data[CTRL_TS_EN];
				pen_en_reg <= wr_data[CTRL_PEN_EN];
				ts_last_reg <= wr_data[CTRL_TS_LAST +: 3];
				gen_last_reg <= wr_data[CTRL_GEN_LAST +: 3];
			end else if (addr == OFS_DELAY) begin
				dly_first_reg <= wr_data[DLY_FIRST +: 4];
				dly_between_reg <= wr_data[DLY_BETWEEN +: 4];
				dly_trail_reg <= wr_data[DLY_TRAIL +: 4];
			end else if (addr == OFS_SLOTS) begin
				slots_reg <= wr_data[15:0];
			end else if (addr == OFS_GEN_CHAN) begin
				gen_chan_reg <= wr_data;
			end else if (addr == OFS_MASK) begin
				mask_reg <= wr_data[2:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Start bits
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ts_start_reg <= 1'b0;
			gen_start_reg <= 1'b0;
		end else begin
			if (ts_begin) begin
				ts_start_reg <= 1'b0;
			end
			if (state_reg == ST_IDLE || ts_active) begin
				gen_start_reg <= 1'b0;
			end
			if (wr_ctrl) begin
				ts_start_reg <= wr_data[CTRL_TS_START] && wr_data[CTRL_TS_EN];
				gen_start_reg <= wr_data[CTRL_GEN_START] && !ts_active;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			is_touch_reg <= 1'b0;
			slot_reg <= 3'h0;
			cnt_reg <= 16'h0000;
			conv_req_reg <= '0;
			store_reg <= 1'b0;
			store_slot_reg <= 3'h0;
			store_val_reg <= 10'h000;
			ts_done_reg <= 1'b0;
			gen_done_reg <= 1'b0;
		end else begin
			conv_req_reg.start <= 1'b0;
			ts_done_reg <= 1'b0;
			gen_done_reg <= 1'b0;
			store_reg <= adv && !ts_begin;
			store_slot_reg <= slot_reg;
			store_val_reg <= (state_reg == ST_WAIT && conv_done) ? conv_data : 10'h000;
			if (cnt_reg != 16'h0000) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
			if (ts_begin) begin
				is_touch_reg <= 1'b1;
				slot_reg <= 3'h0;
				state_reg <= ST_FIRST;
				cnt_reg <= dly_cycles(dly_first_reg);
			end else begin
				case (state_reg)
					ST_IDLE: begin
						if (gen_start_reg) begin
							is_touch_reg <= 1'b0;
							slot_reg <= 3'h0;
							state_reg <= ST_ISSUE;
						end
					end
					ST_FIRST: begin
						if (cnt_reg == 16'h0000) begin
							state_reg <= ST_ISSUE;
						end
					end
					ST_ISSUE: begin
						if (!adv) begin
							if (is_touch_reg) begin
								conv_req_reg <= action_req(cur_act);
							end else begin
								conv_req_reg <= '{start: 1'b1, chan: cur_chan, diff: 1'b0, gain2: 1'b0};
							end
							cnt_reg <= 16'(CONV_MAX_CYC);
							state_reg <= ST_WAIT;
						end
					end
					ST_GAP: begin
						if (cnt_reg == 16'h0000) begin
							state_reg <= ST_ISSUE;
						end
					end
					ST_TRAIL: begin
						if (cnt_reg == 16'h0000) begin
							ts_done_reg <= is_touch_reg;
							gen_done_reg <= !is_touch_reg;
							state_reg <= ST_IDLE;
						end
					end
					default: state_reg <= state_reg;
				endcase
				if (adv) begin
					if (slot_reg == cur_last) begin
						state_reg <= ST_TRAIL;
						cnt_reg <= is_touch_reg ? dly_cycles(dly_trail_reg) : 16'h0000;
					end else begin
						slot_reg <= slot_reg + 3'h1;
						state_reg <= ST_GAP;
						cnt_reg <= is_touch_reg ? dly_cycles(dly_between_reg) : 16'h0000;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result registers
	generate
		for (genvar i = 0; i < 8; i++) begin : g_res
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					res_reg[i] <= 10'h000;
				end else if (store_reg && store_slot_reg == 3'(i)) begin
					res_reg[i] <= store_val_reg;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Panel drive
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= ts_active ? action_drive(cur_act) : '0;
			drive_reg.pen_bias <= pen_en_reg && !ts_en_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status and interrupt
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			status_reg <= 3'h0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= (status_reg & ~((wr_stb && addr == OFS_STATUS) ? wr_data[2:0] : 3'h0))
				| {gen_done_reg, ts_done_reg, pen_evt};
			irq_reg <= |(status_reg & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port
	always_comb begin
		read_val = 32'h0000_0000;
		if (addr == OFS_CTRL) begin
			read_val[CTRL_TS_EN] = ts_en_reg;
			read_val[CTRL_PEN_EN] = pen_en_reg;
			read_val[CTRL_TS_START] = ts_start_reg;
			read_val[CTRL_GEN_START] = gen_start_reg;
			read_val[CTRL_TS_LAST +: 3] = ts_last_reg;
			read_val[CTRL_GEN_LAST +: 3] = gen_last_reg;
		end else if (addr == OFS_DELAY) begin
			read_val[11:0] = {dly_trail_reg, dly_between_reg, dly_first_reg};
		end else if (addr == OFS_SLOTS) begin
			read_val[15:0] = slots_reg;
		end else if (addr == OFS_GEN_CHAN) begin
			read_val = gen_chan_reg;
		end else if (addr == OFS_STATUS) begin
			read_val[2:0] = status_reg;
			read_val[ST_BUSY] = state_reg != ST_IDLE;
			read_val[ST_TS_BUSY] = ts_active;
		end else if (addr == OFS_MASK) begin
			read_val[2:0] = mask_reg;
		end else if (addr[7:5] == RES_PAGE && addr[1:0] == 2'h0) begin
			read_val[9:0] = res_reg[addr[4:2]];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_data_reg <= 32'h0000_0000;
		end else begin
			rd_data_reg <= rd_stb ? read_val : 32'h0000_0000;
		end
	end

	assign rd_data = rd_data_reg;
	assign conv_req = conv_req_reg;
	assign drive = drive_reg;
	assign irq = irq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	// Cycles spent waiting for the converter, for the time limit check
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wait_cnt_reg <= 16'h0000;
		end else begin
			wait_cnt_reg <= (state_reg == ST_WAIT) ? wait_cnt_reg + 16'h0001 : 16'h0000;
		end
	end

	sequence s_dummy_slot;
		state_reg == ST_ISSUE && is_touch_reg && cur_act == ACT_DUMMY && !ts_begin;
	endsequence

	sequence s_zero_store;
		store_reg && store_val_reg == 10'h000;
	endsequence

	a_dummy_stores_zero: assert property (@(posedge clk_sys) disable iff (reset)
		s_dummy_slot |=> s_zero_store and !conv_req.start)
		else $error("Dummy slot did not store zero");

	a_start_self_clear: assert property (@(posedge clk_sys) disable iff (reset)
		ts_begin && !wr_ctrl |=> !ts_start_reg ##0 state_reg == ST_FIRST)
		else $error("Touch start bit did not clear");

	a_no_start_disabled: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == ST_IDLE && !ts_en_reg |=> !ts_active)
		else $error("Touch sequence began while readout disabled");

	a_pen_flag_set: assert property (@(posedge clk_sys) disable iff (reset)
		pen_evt |=> status_reg[ST_PEN] ##1 (irq || !$past(mask_reg[ST_PEN])))
		else $error("Pen touch not flagged");

	a_pen_bias_off: assert property (@(posedge clk_sys) disable iff (reset)
		$past(ts_en_reg) |-> !drive.pen_bias && !(pen_detect_in && $past(pen_en_reg) && pen_evt))
		else $error("Pen detection active during touch readout");

	a_ref_only_touch: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(ts_active) |-> !drive.ref_en && !drive.x_bias && !drive.y_bias && !drive.cur_y1)
		else $error("Touch reference on outside touch sequence");

	a_conv_bounded: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == ST_WAIT |-> wait_cnt_reg <= 16'(CONV_MAX_CYC))
		else $error("Conversion exceeded its time limit");

	a_x_plate_bias: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == ST_WAIT && is_touch_reg && cur_act == ACT_X |-> drive.x_bias && conv_req.chan == CH_Y1)
		else $error("X reading bias or sample wrong");

	a_last_slot_trail: assert property (@(posedge clk_sys) disable iff (reset)
		adv && !ts_begin && slot_reg == cur_last |=> state_reg == ST_TRAIL)
		else $error("Sequence passed the last slot");

	a_result_slot: assert property (@(posedge clk_sys) disable iff (reset)
		store_reg |=> res_reg[$past(store_slot_reg)] == $past(store_val_reg))
		else $error("Result not written to its slot");

	a_touch_done_flag: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == ST_TRAIL && cnt_reg == 16'h0000 && is_touch_reg && !ts_begin |=> ##1 status_reg[ST_TS_DONE])
		else $error("Touch done not flagged");

endmodule

//--- tsq_pkg.sv
// Constants, types and the register map of the touch screen sequencer.
// Assumes one 100 MHz clock and an external 10-bit converter core.
package tsq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DLY_STEP_US = 40;
	localparam int unsigned DLY_STEP_CYC = (DLY_STEP_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned CONV_MAX_US = 10;
	localparam int unsigned CONV_MAX_CYC = (CONV_MAX_US * 1000) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DELAY = 8'h04;
	localparam logic [7:0] OFS_SLOTS = 8'h08;
	localparam logic [7:0] OFS_GEN_CHAN = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [2:0] RES_PAGE = 3'h1;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned CTRL_TS_EN = 0;
	localparam int unsigned CTRL_PEN_EN = 1;
	localparam int unsigned CTRL_TS_START = 2;
	localparam int unsigned CTRL_GEN_START = 3;
	localparam int unsigned CTRL_TS_LAST = 4;
	localparam int unsigned CTRL_GEN_LAST = 8;
	localparam int unsigned DLY_FIRST = 0;
	localparam int unsigned DLY_BETWEEN = 4;
	localparam int unsigned DLY_TRAIL = 8;
	localparam int unsigned ST_PEN = 0;
	localparam int unsigned ST_TS_DONE = 1;
	localparam int unsigned ST_GEN_DONE = 2;
	localparam int unsigned ST_BUSY = 8;
	localparam int unsigned ST_TS_BUSY = 9;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] SLOTS_RST = 16'h0000;
	localparam logic [31:0] GEN_CHAN_RST = 32'h0000_0000;
	localparam logic [3:0] DLY_RST = 4'h0;
	localparam logic [2:0] LAST_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Converter channels
	localparam logic [3:0] CH_COIN = 4'h8;
	localparam logic [3:0] CH_X1 = 4'hC;
	localparam logic [3:0] CH_X2 = 4'hD;
	localparam logic [3:0] CH_Y1 = 4'hE;
	localparam logic [3:0] CH_Y2 = 4'hF;

	typedef enum logic [1:0] {
		ACT_DUMMY = 2'b00,
		ACT_X = 2'b01,
		ACT_Y = 2'b10,
		ACT_CONTACT = 2'b11
	} tsq_action_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FIRST = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT = 3'b011,
		ST_GAP = 3'b100,
		ST_TRAIL = 3'b101
	} tsq_state_t;

	typedef struct packed {
		logic ref_en;
		logic x_bias;
		logic y_bias;
		logic cur_y1;
		logic gnd_x2;
		logic pen_bias;
	} tsq_drive_t;

	typedef struct packed {
		logic start;
		logic [3:0] chan;
		logic diff;
		logic gain2;
	} tsq_conv_req_t;

endpackage

//--- tsq_conv_model.sv
// Converter core stand-in that answers the sequencer's conversion requests.
// Assumes one clock and the request struct of the sequencer package.
`timescale 1ns/100ps
module tsq_conv_model
	import tsq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Sequencer side
	input wire tsq_conv_req_t conv_req,
	input wire tsq_drive_t drive,
	output logic conv_done,
	output logic [9:0] conv_data,
	// Test control
	input wire logic mute,
	input wire logic slow,
	output tsq_drive_t [15:0] seen_drive
);
	logic busy;
	logic [9:0] cnt;
	logic [3:0] chan;
	logic [1:0] mode;

	////////////////////////////////////////////////////////////////////////////
	// Conversion, data toggles while no answer stands
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			cnt <= '0;
			chan <= '0;
			mode <= '0;
			conv_done <= 1'b0;
			conv_data <= 10'h155;
			seen_drive <= '0;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_req.start) begin
				busy <= 1'b1;
				cnt <= slow ? 10'd900 : 10'd2;
				chan <= conv_req.chan;
				mode <= {conv_req.diff, conv_req.gain2};
				seen_drive[conv_req.diff ? 4'h0 : conv_req.chan] <= drive;
			end else if (busy && cnt == 10'd0) begin
				busy <= 1'b0;
				conv_done <= ~mute;
				conv_data <= mode[1] ? {8'hC3, mode[0], 1'b1} : {chan, 6'h15};
			end else if (busy) begin
				cnt <= cnt - 10'd1;
			end
		end
	end
endmodule

//--- touch_screen_adc_sequencer_tb_top.sv
// Self-checking bench for the touch sequencer.
// Assumes the converter stand-in and the sequencer package.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s expected %0h seen %0h", n, e, g); end end
module touch_screen_adc_sequencer_tb_top;
	import tsq_pkg::*;
	logic clk_sys, reset, wr_stb, rd_stb, conv_done, pen_detect_in, irq, mute, slow;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data;
	logic [9:0] conv_data;
	tsq_conv_req_t conv_req;
	tsq_drive_t drive;
	tsq_drive_t [15:0] seen_drive;
	int fails, checks_done;

	tsq_sequencer DUT (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .conv_req(conv_req),
		.conv_done(conv_done), .conv_data(conv_data), .drive(drive),
		.pen_detect_in(pen_detect_in), .irq(irq));
	tsq_conv_model u_model (.clk_sys(clk_sys), .reset(reset), .conv_req(conv_req), .drive(drive),
		.conv_done(conv_done), .conv_data(conv_data), .mute(mute), .slow(slow),
		.seen_drive(seen_drive));

	////////////////////////////////////////////////////////////////////////////
	// Bus and helpers
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK(n, e, d)
	endtask
	task wait_flag(input int b);
		logic [31:0] d;
		d = '0;
		for (int i = 0; i < 5000 && d[b] !== 1'b1; i++) rd(OFS_STATUS, d);
		`CHK("status flag", 1'b1, d[b])
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset();
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("delay", OFS_DELAY, 32'h0);
		rchk("slots", OFS_SLOTS, 32'h0);
		rchk("mask", OFS_MASK, 32'h7);
		rchk("unmapped", 8'h1C, 32'h0);
	endtask
	task t_bad_start();
		wr(OFS_CTRL, 32'h4);
		repeat (5) @(posedge clk_sys);
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("status", OFS_STATUS, 32'h0);
	endtask
	task t_sequence();
		slow <= 1'b1;
		wr(OFS_SLOTS, 32'hE4);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_CTRL, 32'h35);
		repeat (4) @(posedge clk_sys);
		rchk("ctrl", OFS_CTRL, 32'h31);
		wait_flag(ST_TS_DONE);
		`CHK("irq", 1'b1, irq)
		rchk("dummy", 8'h20, 32'h0);
		rchk("x", 8'h24, 32'h395);
		rchk("y", 8'h28, 32'h315);
		rchk("contact", 8'h2C, 32'h30F);
		`CHK("x drive", 6'b110000, seen_drive[CH_Y1])
		`CHK("y drive", 6'b101000, seen_drive[CH_X1])
		`CHK("contact drive", 2'b11, seen_drive[0][2:1])
		`CHK("idle drive", 6'b0, drive)
		wr(OFS_STATUS, 32'h2);
		repeat (2) @(posedge clk_sys);
		#1 `CHK("irq", 1'b0, irq)
		slow <= 1'b0;
	endtask
	task t_general();
		wr(OFS_GEN_CHAN, {24'h0, 4'h3, CH_COIN});
		wr(OFS_STATUS, 32'h7);
		wr(OFS_CTRL, 32'h108);
		wait_flag(ST_GEN_DONE);
		rchk("coin", 8'h20, 32'h215);
		rchk("die temp", 8'h24, 32'h0D5);
		`CHK("gen ref", 1'b0, seen_drive[CH_COIN].ref_en)
		wr(OFS_SLOTS, 32'h1);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_CTRL, 32'h8);
		wr(OFS_CTRL, 32'h5);
		wait_flag(ST_TS_DONE);
		rchk("status", OFS_STATUS, 32'h2);
		rchk("overwrite", 8'h20, 32'h395);
	endtask
	task t_delay_timeout();
		int n;
		n = 0;
		mute <= 1'b1;
		wr(OFS_DELAY, 32'h1);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_CTRL, 32'h9);
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (conv_req.start !== 1'b1 && n < 6000);
		`CHK("first delay", 1'b1, n >= 4000 && n <= 4010)
		wait_flag(ST_TS_DONE);
		rchk("gen dropped", OFS_STATUS, 32'h2);
		rchk("timeout", 8'h20, 32'h0);
		mute <= 1'b0;
	endtask
	task t_pen();
		wr(OFS_STATUS, 32'h7);
		wr(OFS_CTRL, 32'h2);
		pen_detect_in <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 `CHK("pen bias", 1'b1, drive.pen_bias)
		rchk("pen flag", OFS_STATUS, 32'h1);
		`CHK("irq", 1'b1, irq)
		wr(OFS_MASK, 32'h6);
		repeat (2) @(posedge clk_sys);
		#1 `CHK("masked irq", 1'b0, irq)
		wr(OFS_CTRL, 32'h3);
		wr(OFS_STATUS, 32'h1);
		repeat (3) @(posedge clk_sys);
		rchk("pen off", OFS_STATUS, 32'h0);
		`CHK("pen bias", 1'b0, drive.pen_bias)
		pen_detect_in <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#600000;
		fails++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		{addr, wr_data, wr_stb, rd_stb, pen_detect_in, mute, slow} = '0;
		fails = 0;
		checks_done = 0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_bad_start();
		t_sequence();
		t_general();
		t_delay_timeout();
		t_pen();
		conclude();
	end
endmodule
